/* core/operand_addr_pkg.sv */
/*
 * Shared types and constants for the operand addressing unit of an 8-bit
 * pipelined microcontroller core.
 * Assumes a single core clock and a decode stage that presents one opcode
 * with its following bytes at a time.
 */
// Operation
// RULE1 - Direct mode: 8-bit field, RAM and special registers
// RULE2 - Indirect 8-bit via first or second pointer register
// RULE3 - Indirect 16-bit uses data pointer contents
// RULE4 - Register mode picks bank register from opcode
// RULE5 - Register-specific instructions use implied accumulator operand
// RULE6 - Immediate bytes are operand value, not address
// RULE7 - Indexed mode: program read, pointer plus accumulator
// RULE8 - Bit mode selects one of 256 bits
// RULE9 - Most instructions finish in one or two cycles
// RULE10 - External reset active low, holds addressing state; the unit clears its registered operand and illegal flag instead
// RULE11 - External data only accumulator, indirect addressing
// RULE12 - Bit addresses below 128 map to RAM
// RULE13 - Indexed sum wraps modulo 16-bit space
package operand_addr_pkg;

  // ****************************************************************
  // Mode encodings
  // ****************************************************************
  typedef enum logic [8:0] {
    MODE_DIRECT    = 9'h001,
    MODE_INDIRECT8 = 9'h002,
    MODE_INDIRECT16 = 9'h004,
    MODE_REGISTER  = 9'h008,
    MODE_ACCUM     = 9'h010,
    MODE_IMMEDIATE = 9'h020,
    MODE_INDEXED   = 9'h040,
    MODE_BIT       = 9'h080,
    MODE_EXTERNAL  = 9'h100
  } addr_mode_t;

  typedef enum logic [2:0] {
    SPACE_IRAM = 3'h1,
    SPACE_SFR  = 3'h2,
    SPACE_CODE = 3'h4
  } space_t;

  // ****************************************************************
  // Field positions and limits
  // ****************************************************************
  localparam int REG_SEL_MSB = 2;
  localparam int PTR_SEL_BIT = 0;
  localparam int BANK_SHIFT = 3;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] BIT_RAM_LIMIT = 8'h80;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [7:0] BIT_SFR_MASK = 8'hF8;
  localparam logic [1:0] CYCLES_SHORT = 2'h1;
  localparam logic [1:0] CYCLES_LONG = 2'h2;

  typedef struct packed {
    logic       valid;
    addr_mode_t mode;
    logic [7:0] opcode;
    logic [7:0] field;
    logic       write;
  } decode_req_t;

  typedef struct packed {
    logic        valid;
    space_t      space;
    logic [15:0] addr;
    logic [2:0]  bit_pos;
    logic        is_bit;
    logic        is_value;
    logic [7:0]  value;
    logic        use_accum;
    logic        external;
    logic        write;
    logic [1:0]  cycles;
  } operand_t;

endpackage

/* core/operand_reg_select.sv */
/*
 * Working register address calculator.
 * Assumes the bank number comes from the core's status word and is stable
 * while the opcode is presented.
 */
module operand_reg_select
  import operand_addr_pkg::*;
(
  // Selection inputs
  input wire logic [1:0] bank_i,
  input wire logic [2:0] reg_i,
  // Resulting internal RAM address
  output logic [7:0] ram_addr_o
);

  // Each bank holds eight registers packed at the bottom of internal RAM.
  assign ram_addr_o = {3'h0, bank_i, reg_i};

endmodule

/* core/operand_addressing_unit.sv */
/*
 * Operand addressing unit: resolves each decoded operand to a space and
 * address, an implied accumulator, or an immediate value.
 * Assumes the core supplies the working register contents, data pointer and
 * accumulator current for the instruction in decode.
 */
module operand_addressing_unit
  import operand_addr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic external_reset_n_i,
  // Decode side
  input wire decode_req_t req_i,
  input wire logic [1:0] bank_i,
  // Core state
  input wire logic [7:0] first_pointer_register_i,
  input wire logic [7:0] second_pointer_register_i,
  input wire logic [15:0] data_pointer_i,
  input wire logic [7:0] accum_i,
  // Resolved operand
  output operand_t operand_o,
  output logic illegal_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] indexed_addr(input logic [15:0] base,
                                              input logic [7:0] offs);
    indexed_addr = 16'(base + {8'h00, offs}); // RULE13
  endfunction

  function automatic space_t direct_space(input logic [7:0] a);
    direct_space = (a >= SFR_BASE) ? SPACE_SFR : SPACE_IRAM;
  endfunction

  // The low opcode bit picks which pointer register holds the address.
  // Internal and external indirect transfers share this choice.
  function automatic logic [7:0] pointer_pick(input logic [7:0] opc,
                                              input logic [7:0] first,
                                              input logic [7:0] second);
    pointer_pick = opc[PTR_SEL_BIT] ? second : first;
  endfunction

  logic [7:0] reg_addr;
  operand_t op_d;
  operand_t op_q;
  logic illegal_d;
  logic illegal_q;

  operand_reg_select u_reg_select (
    .bank_i(bank_i),
    .reg_i(req_i.opcode[REG_SEL_MSB:0]),
    .ram_addr_o(reg_addr)
  );

  // ****************************************************************
  // Operand resolution
  // ****************************************************************
  always_comb begin
    op_d = '0;
    op_d.valid = req_i.valid;
    op_d.space = SPACE_IRAM;
    op_d.write = req_i.write;
    op_d.cycles = CYCLES_LONG; // RULE9
    illegal_d = 1'b0;
    case (req_i.mode)
      MODE_DIRECT: begin
        op_d.addr = {8'h00, req_i.field}; // RULE1
        op_d.space = direct_space(req_i.field); // RULE1
      end
      MODE_INDIRECT8: begin
        op_d.addr = {8'h00, pointer_pick(req_i.opcode, first_pointer_register_i,
                                         second_pointer_register_i)}; // RULE2
      end
      MODE_INDIRECT16: begin
        op_d.addr = data_pointer_i; // RULE3
      end
      MODE_EXTERNAL: begin
        // Only the accumulator may pair with external data, always indirect.
        op_d.external = 1'b1; // RULE11
        op_d.use_accum = 1'b1; // RULE11
        op_d.addr = req_i.opcode[1] ? data_pointer_i
                  : {8'h00, pointer_pick(req_i.opcode, first_pointer_register_i,
                                         second_pointer_register_i)}; // RULE11
      end
      MODE_REGISTER: begin
        op_d.addr = {8'h00, reg_addr}; // RULE4
        op_d.cycles = CYCLES_SHORT; // RULE9
      end
      MODE_ACCUM: begin
        op_d.use_accum = 1'b1; // RULE5
        op_d.cycles = CYCLES_SHORT; // RULE9
      end
      MODE_IMMEDIATE: begin
        op_d.is_value = 1'b1; // RULE6
        op_d.value = req_i.field; // RULE6
        // An immediate has nowhere to be written back to.
        illegal_d = req_i.valid & req_i.write;
      end
      MODE_INDEXED: begin
        op_d.space = SPACE_CODE; // RULE7
        op_d.addr = indexed_addr(data_pointer_i, accum_i); // RULE7
        op_d.write = 1'b0;
        illegal_d = req_i.valid & req_i.write; // RULE7
      end
      MODE_BIT: begin
        op_d.is_bit = 1'b1; // RULE8
        op_d.bit_pos = req_i.field[2:0]; // RULE8
        if (req_i.field < BIT_RAM_LIMIT) begin
          op_d.addr = {8'h00, 8'(BIT_RAM_BASE + {4'h0, req_i.field[6:3]})}; // RULE12
        end else begin
          op_d.space = SPACE_SFR; // RULE12
          op_d.addr = {8'h00, req_i.field & BIT_SFR_MASK}; // RULE12
        end
      end
      default: begin
        illegal_d = req_i.valid;
        op_d.valid = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  // Reset is sampled by the core clock; the pin pull-up lives in the pad.
  always_ff @(posedge clk_i) begin
    if (!external_reset_n_i) begin
      op_q <= '0; // RULE10
      op_q.space <= SPACE_IRAM;
    end else begin
      op_q <= op_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!external_reset_n_i) begin
      illegal_q <= 1'b0; // RULE10
    end else begin
      illegal_q <= illegal_d;
    end
  end

  assign operand_o = op_q;
  assign illegal_o = illegal_q;

endmodule

/* tb/operand_addressing_unit_asserts.sv */
/* Checker for the operand addressing unit.
   Assumes it is bound to the unit; one clock, reset active low. */
module operand_addressing_unit_asserts import operand_addr_pkg::*; (
  input wire logic clk_i,
  input wire logic external_reset_n_i,
  input wire decode_req_t req_i,
  input wire logic [1:0] bank_i,
  input wire logic [7:0] first_pointer_register_i,
  input wire logic [7:0] second_pointer_register_i,
  input wire logic [15:0] data_pointer_i,
  input wire logic [7:0] accum_i,
  input wire operand_t operand_o,
  input wire logic illegal_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] vm;
  assign vm = req_i.valid ? req_i.mode : 9'h000;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!external_reset_n_i);
  chk_direct_addr:
    assert property (vm == MODE_DIRECT |=> operand_o.addr == 16'($past(req_i.field)))
    else $error("direct");
  chk_indirect_second:
    assert property (vm == MODE_INDIRECT8 && req_i.opcode[0] |=>
      operand_o.addr[7:0] == $past(second_pointer_register_i)) else $error("indirect");
  chk_register_bank:
    assert property (vm == MODE_REGISTER |=> operand_o.addr[4:0] ==
      {$past(bank_i), $past(req_i.opcode[2:0])} && operand_o.cycles == CYCLES_SHORT)
    else $error("reg");
  chk_accum_implied:
    assert property (vm == MODE_ACCUM |=> operand_o.use_accum) else $error("accum");
  chk_imm_value:
    assert property (vm == MODE_IMMEDIATE |=> operand_o.is_value &&
      operand_o.value == $past(req_i.field)) else $error("immediate");
  chk_indexed_sum:
    assert property (vm == MODE_INDEXED |=> operand_o.space == SPACE_CODE &&
      operand_o.addr == 16'($past(data_pointer_i) + {8'h00, $past(accum_i)}))
    else $error("indexed");
  chk_bit_select:
    assert property (vm == MODE_BIT |=> operand_o.is_bit &&
      operand_o.bit_pos == $past(req_i.field[2:0])) else $error("bit");
  chk_reset_clear:
    assert property (disable iff (1'b0) !external_reset_n_i |=> !operand_o.valid && !illegal_o)
    else $error("reset");
  cover property (vm == MODE_INDEXED);
  cover property (vm == MODE_EXTERNAL);
  cover property (illegal_o);
endmodule
bind operand_addressing_unit operand_addressing_unit_asserts operand_addressing_unit_asserts_i (
  .clk_i(clk_i), .external_reset_n_i(external_reset_n_i), .req_i(req_i), .bank_i(bank_i),
  .first_pointer_register_i(first_pointer_register_i), .accum_i(accum_i),
  .second_pointer_register_i(second_pointer_register_i), .data_pointer_i(data_pointer_i),
  .operand_o(operand_o), .illegal_o(illegal_o));

/* tb/core_state_model.sv */
/* Core state seen by the unit: bank, pointers, accumulator.
   Assumes the bench clock; values move on the falling edge. */
module core_state_model (
  input wire logic clk_i,
  output logic [41:0] state_o
);
  timeunit 1ns;
  timeprecision 1ps;
  integer seed = 32'h7376;
  always @(negedge clk_i) begin
    state_o <= 42'({$random(seed), $random(seed)} >> 22);
  end
endmodule

/* tb/operand_addressing_unit_tb_top.sv */
/* Random requests checked against a model of the addressing rules.
   Assumes the core state model drives the core-side inputs. */
module operand_addressing_unit_tb_top import operand_addr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n = 1'b0;
  decode_req_t req = '0;
  logic [41:0] cs;
  operand_t op;
  logic ill;
  int errors = 0, tests_run = 0, seed = 32'h7376, ev = -1, ea = -1, ei = -1, f, o;
  int es = -1, ef = -1, ek = -1, eq = -1;
  addr_mode_t m;
  initial forever #4 clk_i = ~clk_i;
  core_state_model core_state_model_i (.clk_i(clk_i), .state_o(cs));
  operand_addressing_unit operand_addressing_unit_i (.clk_i(clk_i),
    .external_reset_n_i(rst_n), .req_i(req), .bank_i(cs[41:40]), .accum_i(cs[7:0]),
    .first_pointer_register_i(cs[39:32]), .second_pointer_register_i(cs[31:24]),
    .data_pointer_i(cs[23:8]), .operand_o(op), .illegal_o(ill));
  task automatic chk(string nm, logic [15:0] seen, int e);
    if (e >= 0) begin
      tests_run++;
      if (seen !== 16'(e)) begin
        errors++;
        $display("CHECK FAILED %s expected %0h seen %0h", nm, e, seen);
      end
    end
  endtask
  task automatic give_verdict;
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (3) @(negedge clk_i);
    chk("valid", 16'(op.valid), 0);
    chk("illegal", 16'(ill), 0);
    rst_n = 1'b1;
    for (int n = 0; n < 400; n++) begin
      @(negedge clk_i);
      chk("valid", 16'(op.valid), ev);
      chk("addr", op.addr, ea);
      chk("illegal", 16'(ill), ei);
      chk("space", 16'(op.space), es);
      chk("flags", 16'({op.external, op.use_accum, op.write}), ef);
      chk("cycles", 16'(op.cycles), ek);
      chk("value", 16'({op.is_value, op.value}), eq);
      o = $random(seed);
      f = $random(seed);
      m = addr_mode_t'(9'h001 << (o[11:8] % 10));
      req <= '{valid: o[0], mode: m, opcode: o[23:16], field: f[7:0], write: o[1] & o[2]};
      rst_n <= (n != 200);
      #1;
      case (m)
        MODE_DIRECT: ea = f[7:0];
        MODE_INDIRECT8: ea = o[16] ? cs[31:24] : cs[39:32];
        MODE_INDIRECT16: ea = cs[23:8];
        MODE_REGISTER: ea = {cs[41:40], o[18:16]};
        MODE_INDEXED: ea = (cs[23:8] + cs[7:0]) % 65536;
        MODE_BIT: ea = f[7] ? (f[7:0] & 8'hF8) : (32 + f[6:3]);
        MODE_EXTERNAL: ea = o[17] ? cs[23:8] : (o[16] ? cs[31:24] : cs[39:32]);
        default: ea = -1;
      endcase
      ei = o[0] && (!m || (o[1] && o[2] && (m == MODE_IMMEDIATE || m == MODE_INDEXED)));
      ev = (ei && m) ? -1 : int'(o[0] && m != 0);
      es = (m == MODE_DIRECT || m == MODE_BIT) ? (f[7] ? int'(SPACE_SFR) : int'(SPACE_IRAM))
         : (m == MODE_INDEXED ? int'(SPACE_CODE) : -1);
      ef = (m == MODE_EXTERNAL ? 6 : (m == MODE_ACCUM ? 2 : 0))
         + int'(m != MODE_INDEXED && o[1] && o[2]);
      ek = (m == MODE_REGISTER || m == MODE_ACCUM) ? int'(CYCLES_SHORT) : int'(CYCLES_LONG);
      eq = (m == MODE_IMMEDIATE) ? 256 + f[7:0] : 0;
      if (!o[0] || ei) begin
        ea = -1;
        es = -1;
        ef = -1;
        ek = -1;
        eq = -1;
      end
      if (n == 200) begin
        ev = 0;
        ea = 0;
        ei = 0;
        es = int'(SPACE_IRAM);
        ef = 0;
        ek = 0;
        eq = 0;
      end
    end
    give_verdict();
  end
endmodule
